// ===== design/context_irq_pulse.sv
// Turns descriptor completion reports of a group of DMA contexts into
// registered interrupt pulses that last as long as each report, one per context.
// Assumes reports are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module context_irq_pulse #(
  parameter int N = 8,
  parameter bit ANY_KIND = 1'b0
) (
  input wire logic mclk, // Register clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire isoch_irq_pkg::completion_t [N-1:0] report, // Completion reports
  output logic [N-1:0] pulse // Interrupt pulse per context
);

  // ************************************************************
  // Qualification
  // ************************************************************
  // A pulse needs a completion whose interrupt bits are both one
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      pulse <= '0;
    else
      for (int i = 0; i < N; i++)
        pulse[i] <= report[i].done && (ANY_KIND || report[i].last_kind)
                    && (report[i].int_ctl == isoch_irq_pkg::INT_CTL_ALWAYS);
  end

  AST_PULSE_CAUSE: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(pulse[0]) |-> $past(report[0].done) && $past(report[0].int_ctl) == 2'h3)
    else $error("context pulse without a qualifying completion");

endmodule
`default_nettype wire

// ===== design/isoch_context_interrupt_regs.sv
// Isochronous per-context interrupt event and mask registers with summary.
// Assumes an Avalon-MM master on the slave port and completion reports
// from the transmit and receive DMA contexts, all on mclk.
//
// Function
// - Transmit last-output completion with interrupt pulses
// - Receive input completion with interrupt pulses
// - Event bit set by edge or set-write
// - Event bit cleared only by clear-write
// - Transmit events at 90h, masked read at 94h
// - Receive events at A0h, masked read at A4h
// - Transmit bit n feeds transmit summary bit 6
// - Receive bit n feeds receive summary bit 7
// - Transmit upper bits read zero, ignore writes
// - Receive upper bits read zero, ignore writes
// - Transmit mask enables each context's contribution
// - Transmit mask at 98h/9Ch, reads unmasked
// - Transmit interrupt needs summary and mask bit 6
// - Receive interrupt needs summary and mask bit 7
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module isoch_context_interrupt_regs #(
  parameter int TX_N = 8,
  parameter int RX_N = 4
) (
  input wire logic mclk, // Register clock, 25 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire isoch_irq_pkg::bus_req_t bus_req, // Avalon-MM request
  output logic waitrequest, // Avalon-MM wait
  output logic [31:0] readdata, // Avalon-MM read data
  input wire isoch_irq_pkg::completion_t [TX_N-1:0] tx_report, // Transmit completions
  input wire isoch_irq_pkg::completion_t [RX_N-1:0] rx_report, // Receive completions
  output logic tx_iso_summary_event, // Transmit summary event
  output logic rx_iso_summary_event, // Receive summary event
  output logic irq // Level interrupt
);

  // ************************************************************
  // Declarations
  // ************************************************************
  isoch_irq_pkg::bus_state_t bus_state;
  logic [TX_N-1:0] tx_pulse;
  logic [RX_N-1:0] rx_pulse;
  logic [TX_N-1:0] tx_event;
  logic [TX_N-1:0] tx_mask;
  logic [RX_N-1:0] rx_event;
  logic [RX_N-1:0] rx_mask;
  logic [7:0] summary_status;
  logic [7:0] summary_mask;
  logic accept_wr;
  logic accept_rd;
  logic [7:0] wbits;
  logic [TX_N-1:0] tx_ev_set;
  logic [TX_N-1:0] tx_ev_clr;
  logic [TX_N-1:0] tx_mk_set;
  logic [TX_N-1:0] tx_mk_clr;
  logic [RX_N-1:0] rx_ev_set;
  logic [RX_N-1:0] rx_ev_clr;
  logic [RX_N-1:0] rx_mk_set;
  logic [RX_N-1:0] rx_mk_clr;
  logic next_tx_summary;
  logic next_rx_summary;
  logic [7:0] next_summary_status;
  logic [31:0] next_readdata;

  // ************************************************************
  // Context pulse generation
  // ************************************************************
  context_irq_pulse #(.N(TX_N), .ANY_KIND(1'b0)) u_tx_pulse (
    .mclk(mclk),
    .resetn(resetn),
    .report(tx_report),
    .pulse(tx_pulse)
  );

  context_irq_pulse #(.N(RX_N), .ANY_KIND(1'b1)) u_rx_pulse (
    .mclk(mclk),
    .resetn(resetn),
    .report(rx_report),
    .pulse(rx_pulse)
  );

  // ************************************************************
  // Avalon-MM handshake
  // ************************************************************
  // Every access waits exactly one cycle; the answer is then registered
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      bus_state <= isoch_irq_pkg::BUS_IDLE;
    else
      case (bus_state)
        isoch_irq_pkg::BUS_IDLE:
          if (bus_req.read || bus_req.write)
            bus_state <= isoch_irq_pkg::BUS_ANSWER;
        isoch_irq_pkg::BUS_ANSWER:
          bus_state <= isoch_irq_pkg::BUS_IDLE;
        default:
          bus_state <= isoch_irq_pkg::BUS_IDLE;
      endcase
  end

  // Waitrequest low only in the answer cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      waitrequest <= 1'b1;
    else
      waitrequest <= !(bus_state == isoch_irq_pkg::BUS_IDLE && (bus_req.read || bus_req.write));
  end

  // Effects take place at the edge where the master sees waitrequest low
  assign accept_wr = bus_req.write && !waitrequest;
  assign accept_rd = bus_req.read && !waitrequest;

  // Only the low byte holds implemented bits; upper lanes are dropped
  assign wbits = bus_req.byteenable[0] ? bus_req.writedata[7:0] : 8'h00;

  // ************************************************************
  // Write strobes
  // ************************************************************
  // Upper data bits never reach a bank, so reserved bits ignore writes
  always_comb
  begin
    tx_ev_set = '0;
    tx_ev_clr = '0;
    tx_mk_set = '0;
    tx_mk_clr = '0;
    rx_ev_set = '0;
    rx_ev_clr = '0;
    rx_mk_set = '0;
    rx_mk_clr = '0;
    if (accept_wr)
      case (bus_req.address)
        isoch_irq_pkg::TX_EVENT_SET: tx_ev_set = wbits[TX_N-1:0];
        isoch_irq_pkg::TX_EVENT_CLEAR: tx_ev_clr = wbits[TX_N-1:0];
        isoch_irq_pkg::TX_MASK_SET: tx_mk_set = wbits[TX_N-1:0];
        isoch_irq_pkg::TX_MASK_CLEAR: tx_mk_clr = wbits[TX_N-1:0];
        isoch_irq_pkg::RX_EVENT_SET: rx_ev_set = wbits[RX_N-1:0];
        isoch_irq_pkg::RX_EVENT_CLEAR: rx_ev_clr = wbits[RX_N-1:0];
        isoch_irq_pkg::RX_MASK_SET: rx_mk_set = wbits[RX_N-1:0];
        isoch_irq_pkg::RX_MASK_CLEAR: rx_mk_clr = wbits[RX_N-1:0];
        default: ;
      endcase
  end

  // ************************************************************
  // Event and mask banks
  // ************************************************************
  set_clear_bank #(.W(TX_N), .RESET_VALUE(isoch_irq_pkg::EVENT_RESET[TX_N-1:0])) u_tx_event (
    .mclk(mclk),
    .resetn(resetn),
    .hw_level(tx_pulse),
    .sw_set(tx_ev_set),
    .sw_clear(tx_ev_clr),
    .bits(tx_event)
  );

  set_clear_bank #(.W(TX_N), .RESET_VALUE(isoch_irq_pkg::MASK_RESET[TX_N-1:0])) u_tx_mask (
    .mclk(mclk),
    .resetn(resetn),
    .hw_level('0),
    .sw_set(tx_mk_set),
    .sw_clear(tx_mk_clr),
    .bits(tx_mask)
  );

  set_clear_bank #(.W(RX_N), .RESET_VALUE(isoch_irq_pkg::EVENT_RESET[RX_N-1:0])) u_rx_event (
    .mclk(mclk),
    .resetn(resetn),
    .hw_level(rx_pulse),
    .sw_set(rx_ev_set),
    .sw_clear(rx_ev_clr),
    .bits(rx_event)
  );

  set_clear_bank #(.W(RX_N), .RESET_VALUE(isoch_irq_pkg::MASK_RESET[RX_N-1:0])) u_rx_mask (
    .mclk(mclk),
    .resetn(resetn),
    .hw_level('0),
    .sw_set(rx_mk_set),
    .sw_clear(rx_mk_clr),
    .bits(rx_mask)
  );

  // ************************************************************
  // Summary events
  // ************************************************************
  // Each context counts toward the summary only while its mask bit is set
  assign next_tx_summary = |(tx_event & tx_mask);
  assign next_rx_summary = |(rx_event & rx_mask);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_iso_summary_event <= 1'b0;
      rx_iso_summary_event <= 1'b0;
    end
    else
    begin
      tx_iso_summary_event <= next_tx_summary;
      rx_iso_summary_event <= next_rx_summary;
    end
  end

  // ************************************************************
  // Interrupt status, mask and output
  // ************************************************************
  // Sticky status; a read clears it but a summary still high sets it again
  always_comb
  begin
    next_summary_status = summary_status;
    if (accept_rd && bus_req.address == isoch_irq_pkg::SUMMARY_STATUS)
      next_summary_status = isoch_irq_pkg::SUMMARY_RESET;
    next_summary_status[isoch_irq_pkg::TX_SUMMARY_BIT] =
      next_summary_status[isoch_irq_pkg::TX_SUMMARY_BIT] | tx_iso_summary_event;
    next_summary_status[isoch_irq_pkg::RX_SUMMARY_BIT] =
      next_summary_status[isoch_irq_pkg::RX_SUMMARY_BIT] | rx_iso_summary_event;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      summary_status <= isoch_irq_pkg::SUMMARY_RESET;
    else
      summary_status <= next_summary_status;
  end

  // Only bits 6 and 7 of the summary mask are implemented
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      summary_mask <= isoch_irq_pkg::SUMMARY_RESET;
    else if (accept_wr && bus_req.address == isoch_irq_pkg::SUMMARY_MASK)
    begin
      summary_mask[isoch_irq_pkg::TX_SUMMARY_BIT] <= wbits[isoch_irq_pkg::TX_SUMMARY_BIT];
      summary_mask[isoch_irq_pkg::RX_SUMMARY_BIT] <= wbits[isoch_irq_pkg::RX_SUMMARY_BIT];
    end
  end

  // Interrupt level follows the sticky status gated by the summary mask
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= (next_summary_status[isoch_irq_pkg::TX_SUMMARY_BIT]
              && summary_mask[isoch_irq_pkg::TX_SUMMARY_BIT])
          || (next_summary_status[isoch_irq_pkg::RX_SUMMARY_BIT]
              && summary_mask[isoch_irq_pkg::RX_SUMMARY_BIT]);
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Event clear addresses read masked events; mask addresses read unmasked
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (bus_req.address)
      isoch_irq_pkg::TX_EVENT_SET: next_readdata[TX_N-1:0] = tx_event;
      isoch_irq_pkg::TX_EVENT_CLEAR: next_readdata[TX_N-1:0] = tx_event & tx_mask;
      isoch_irq_pkg::TX_MASK_SET,
      isoch_irq_pkg::TX_MASK_CLEAR: next_readdata[TX_N-1:0] = tx_mask;
      isoch_irq_pkg::RX_EVENT_SET: next_readdata[RX_N-1:0] = rx_event;
      isoch_irq_pkg::RX_EVENT_CLEAR: next_readdata[RX_N-1:0] = rx_event & rx_mask;
      isoch_irq_pkg::RX_MASK_SET,
      isoch_irq_pkg::RX_MASK_CLEAR: next_readdata[RX_N-1:0] = rx_mask;
      isoch_irq_pkg::SUMMARY_STATUS: next_readdata[7:0] = summary_status;
      isoch_irq_pkg::SUMMARY_MASK: next_readdata[7:0] = summary_mask;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Captured as waitrequest drops, so the data is stable in the answer cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      readdata <= 32'h0000_0000;
    else if (bus_req.read && bus_state == isoch_irq_pkg::BUS_IDLE)
      readdata <= next_readdata;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence tx_edge_s;
    !tx_pulse[0] ##1 tx_pulse[0];
  endsequence

  sequence tx_set_seen_s;
    ##1 tx_event[0];
  endsequence

  AST_TX_EDGE_SETS: assert property (@(posedge mclk) disable iff (!resetn)
    tx_edge_s |-> tx_set_seen_s)
    else $error("transmit event bit not set by pulse edge");

  AST_TX_LAST_ONLY: assert property (@(posedge mclk) disable iff (!resetn)
    tx_report[0].done && !tx_report[0].last_kind |=> !tx_pulse[0])
    else $error("transmit pulse from a non-last command");

  AST_RX_ANY_INPUT: assert property (@(posedge mclk) disable iff (!resetn)
    rx_report[0].done && rx_report[0].int_ctl == 2'h3 |=> rx_pulse[0] ##2 rx_event[0])
    else $error("receive completion did not set its event");

  AST_CLEAR_WORKS: assert property (@(posedge mclk) disable iff (!resetn)
    accept_wr && bus_req.address == 8'h94 && wbits[0] && !tx_pulse[0] && !tx_ev_set[0]
    |=> !tx_event[0])
    else $error("clear write did not clear transmit event");

  AST_TX_MASKED_READ: assert property (@(posedge mclk) disable iff (!resetn)
    bus_req.read && bus_state == isoch_irq_pkg::BUS_IDLE && bus_req.address == 8'h94
    |=> readdata == {24'h000000, $past(tx_event & tx_mask)})
    else $error("masked transmit read wrong");

  AST_RX_MASKED_READ: assert property (@(posedge mclk) disable iff (!resetn)
    bus_req.read && bus_state == isoch_irq_pkg::BUS_IDLE && bus_req.address == 8'hA4
    |=> readdata == {28'h0000000, $past(rx_event & rx_mask)})
    else $error("masked receive read wrong");

  AST_TX_SUMMARY: assert property (@(posedge mclk) disable iff (!resetn)
    tx_iso_summary_event == $past(|(tx_event & tx_mask)))
    else $error("transmit summary mismatch");

  AST_RX_SUMMARY: assert property (@(posedge mclk) disable iff (!resetn)
    rx_event[3] && rx_mask[3] |=> rx_iso_summary_event)
    else $error("receive summary missed context 3");

  AST_MASK_READ_RAW: assert property (@(posedge mclk) disable iff (!resetn)
    bus_req.read && bus_state == isoch_irq_pkg::BUS_IDLE && bus_req.address == 8'h9C
    |=> readdata[7:0] == $past(tx_mask) && readdata[31:8] == 24'h000000)
    else $error("mask read at clear address not raw");

  AST_IRQ_GATED: assert property (@(posedge mclk) disable iff (!resetn)
    irq |-> $past(summary_mask[6] && next_summary_status[6]
                  || summary_mask[7] && next_summary_status[7]))
    else $error("interrupt without masked summary");

  AST_ONE_WAIT: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low longer than one cycle");

  AST_RESET_ZERO: assert property (@(posedge mclk)
    !resetn |=> tx_event == 8'h00 || !resetn)
    else $error("transmit events not zero after reset");

endmodule
`default_nettype wire

// ===== design/isoch_irq_pkg.sv
// Constants and carrier types for the isochronous context interrupt registers.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one clock.
`default_nettype none

package isoch_irq_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] TX_EVENT_SET = 8'h90;
  localparam logic [7:0] TX_EVENT_CLEAR = 8'h94;
  localparam logic [7:0] TX_MASK_SET = 8'h98;
  localparam logic [7:0] TX_MASK_CLEAR = 8'h9C;
  localparam logic [7:0] RX_EVENT_SET = 8'hA0;
  localparam logic [7:0] RX_EVENT_CLEAR = 8'hA4;
  localparam logic [7:0] RX_MASK_SET = 8'hA8;
  localparam logic [7:0] RX_MASK_CLEAR = 8'hAC;
  localparam logic [7:0] SUMMARY_STATUS = 8'hC0;
  localparam logic [7:0] SUMMARY_MASK = 8'hC4;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int TX_CONTEXTS = 8;
  localparam int RX_CONTEXTS = 4;
  localparam int TX_SUMMARY_BIT = 6;
  localparam int RX_SUMMARY_BIT = 7;
  localparam logic [1:0] INT_CTL_ALWAYS = 2'h3;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] SUMMARY_RESET = 8'h00;

  // ************************************************************
  // Carrier types
  // ************************************************************
  // One descriptor completion report from a DMA context
  typedef struct packed {
    logic done;        // Command completed this cycle
    logic last_kind;   // Command was of the last-output kind
    logic [1:0] int_ctl; // Interrupt control bits of the command
  } completion_t;

  // Avalon-MM request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } bus_req_t;

  // Bus answer states, Gray coded
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ANSWER = 2'h1
  } bus_state_t;

endpackage

`default_nettype wire

// ===== design/set_clear_bank.sv
// A bank of bits set by hardware edges or software, cleared only by software.
// Assumes software strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none

module set_clear_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic mclk, // Register clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [W-1:0] hw_level, // Hardware interrupt level
  input wire logic [W-1:0] sw_set, // Software set strobe
  input wire logic [W-1:0] sw_clear, // Software clear strobe
  output logic [W-1:0] bits // Stored bits
);

  logic [W-1:0] prev_level;
  logic [W-1:0] rising;

  // Only the asserting edge sets, so a held level does not refill a cleared bit
  assign rising = hw_level & ~prev_level;

  // Edge history
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      prev_level <= '0;
    else
      prev_level <= hw_level;
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      bits <= RESET_VALUE;
    else
      bits <= (bits & ~sw_clear) | sw_set | rising;
  end

  AST_ONLY_CLEAR_DROPS: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(bits[0]) |-> $past(sw_clear[0]))
    else $error("bank bit dropped without a clear strobe");

endmodule
`default_nettype wire

// ===== testbench/host_sw_model.sv
// Host software side: issues single Avalon-MM reads and writes.
// Assumes the block answers with waitrequest and registered readdata.
`timescale 1ns/1ps
`default_nettype none

module host_sw_model (
  input wire logic mclk, // Register clock
  input wire logic resetn, // Reset, active low
  input wire logic start, // Request from the bench
  input wire logic wr, // 1 for a write
  input wire logic [7:0] addr, // Byte offset
  input wire logic [31:0] wdata, // Write data
  output logic done, // One-cycle completion
  output logic [31:0] rdata, // Captured read data
  output isoch_irq_pkg::bus_req_t bus_req, // Request to the block
  input wire logic waitrequest, // Slave wait
  input wire logic [31:0] readdata // Slave read data
);
  // ************************************************************
  // Bus master
  // ************************************************************
  // Held until waitrequest is sampled low; released address and write data lines show the inverse
  // so a block that keeps using stale values cannot pass by luck
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_req <= '0;
      done <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        bus_req.read <= !wr;
        bus_req.write <= wr;
        bus_req.address <= addr;
        bus_req.byteenable <= 4'hF;
        bus_req.writedata <= wdata;
      end
      else if ((bus_req.read || bus_req.write) && !waitrequest)
      begin
        rdata <= readdata;
        done <= 1'b1;
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
        bus_req.address <= ~bus_req.address;
        bus_req.writedata <= ~bus_req.writedata;
      end
    end
  end
endmodule

`default_nettype wire

// ===== testbench/isoch_context_interrupt_regs_test.sv
// Self-checking bench for the isochronous context interrupt registers.
// Assumes the host model as bus master; the bench drives completions.
`timescale 1ns/1ps
`default_nettype none

module isoch_context_interrupt_regs_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  isoch_irq_pkg::completion_t [7:0] tx_rep = '0;
  isoch_irq_pkg::completion_t [3:0] rx_rep = '0;
  isoch_irq_pkg::bus_req_t bus_req;
  logic waitrequest, done, tx_sum, rx_sum, irq;
  logic [31:0] readdata, rdata;
  int err_total = 0;
  int n_checks = 0;
  int tx_ev, tx_mk, rx_ev, rx_mk, lk, ic, r;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  isoch_context_interrupt_regs u_dut (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
    .waitrequest(waitrequest), .readdata(readdata), .tx_report(tx_rep), .rx_report(rx_rep),
    .tx_iso_summary_event(tx_sum), .rx_iso_summary_event(rx_sum), .irq(irq));
  host_sw_model u_host (.mclk(mclk), .resetn(resetn), .start(start), .wr(wr), .addr(addr),
    .wdata(wdata), .done(done), .rdata(rdata), .bus_req(bus_req), .waitrequest(waitrequest),
    .readdata(readdata));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask

  // One transfer; the wait is bounded so a dead slave cannot hang us
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    start <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    start <= 1'b0;
    do @(negedge mclk); while (done !== 1'b1 && ++n < 50);
    if (n >= 50)
    begin
      $display("ERROR bus done expected 1 seen 0");
      err_total++;
      print_verdict();
    end
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask

  // Event and mask registers and both summaries against the model
  task automatic check_all();
    rd("tx event set", 8'h90, tx_ev);
    rd("tx event clear", 8'h94, tx_ev & tx_mk);
    rd("tx mask set", 8'h98, tx_mk);
    rd("tx mask clear", 8'h9C, tx_mk);
    rd("rx event set", 8'hA0, rx_ev);
    rd("rx event clear", 8'hA4, rx_ev & rx_mk);
    rd("rx mask", 8'hA8, rx_mk);
    chk("tx summary", |(tx_ev & tx_mk), tx_sum);
    chk("rx summary", |(rx_ev & rx_mk), rx_sum);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog: the run needs about 3000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    print_verdict();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(32'hFE22C607));
    {tx_ev, tx_mk, rx_ev, rx_mk} = '0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    check_all();
    rd("unmapped", 8'hB0, 32'h0);
    bus(1'b1, 8'hB0, 32'hFFFFFFFF);
    // Mask set then clear with random data
    r = $urandom;
    bus(1'b1, 8'h98, r);
    tx_mk = r & 8'hFF;
    r = $urandom;
    bus(1'b1, 8'h9C, r);
    tx_mk = tx_mk & ~r & 8'hFF;
    bus(1'b1, 8'hA8, 32'hFFFFFFFF);
    rx_mk = 4'hF;
    // Set writes, upper bits must not stick
    r = $urandom | 32'hFFFFFF00;
    bus(1'b1, 8'h90, r);
    tx_ev = r & 8'hFF;
    r = $urandom | 32'hFFFFFFF0;
    bus(1'b1, 8'hA0, r);
    rx_ev = r & 4'hF;
    check_all();
    bus(1'b1, 8'h94, 32'h0);
    bus(1'b1, 8'hA4, 32'h0);
    check_all();
    // Every context against every command kind and control value
    for (int i = 0; i < 64; i++)
    begin
      lk = (i >> 3) & 1;
      ic = i >> 4;
      bus(1'b1, 8'h94, 32'hFF);
      bus(1'b1, 8'hA4, 32'hF);
      tx_ev = 0;
      rx_ev = 0;
      @(posedge mclk);
      tx_rep[i % 8] <= {1'b1, lk[0], ic[1:0]};
      rx_rep[i % 4] <= {1'b1, lk[0], ic[1:0]};
      @(posedge mclk);
      tx_rep <= '0;
      rx_rep <= '0;
      repeat (4) @(posedge mclk);
      if (lk == 1 && ic == 3)
        tx_ev = 1 << (i % 8);
      if (ic == 3)
        rx_ev = 1 << (i % 4);
      check_all();
    end
    // A held report sets once: clearing it while held must stick
    @(posedge mclk);
    tx_rep[0] <= 4'hF;
    repeat (4) @(posedge mclk);
    bus(1'b1, 8'h94, 32'h1);
    tx_ev = tx_ev & ~1;
    check_all();
    @(posedge mclk);
    tx_rep <= '0;
    // Interrupt raise, mask, service and clear
    bus(1'b1, 8'h98, 32'hFF);
    tx_mk = 8'hFF;
    bus(1'b1, 8'h90, 32'h20);
    tx_ev = tx_ev | 8'h20;
    bus(1'b1, 8'hC4, 32'h0);
    repeat (3) @(negedge mclk);
    chk("irq masked", 1'b0, irq);
    bus(1'b1, 8'hC4, 32'h40);
    repeat (3) @(negedge mclk);
    chk("irq tx", 1'b1, irq);
    // Receive bit is still sticky from the loop, since no status read came yet
    rd("summary status", 8'hC0, 32'hC0);
    bus(1'b1, 8'h94, 32'hFF);
    tx_ev = 0;
    // Receive events must go too, or the read below would set bit 7 again
    bus(1'b1, 8'hA4, 32'hF);
    rx_ev = 0;
    bus(1'b0, 8'hC0, 32'h0);
    rd("summary status", 8'hC0, 32'h0);
    chk("irq cleared", 1'b0, irq);
    bus(1'b1, 8'hC4, 32'h80);
    bus(1'b1, 8'hA0, 32'h1);
    rx_ev = 1;
    repeat (3) @(negedge mclk);
    chk("irq rx", 1'b1, irq);
    check_all();
    print_verdict();
  end
endmodule

`default_nettype wire
